/* File: logic/usbc_cmd.v */
// command interpreter: endpoint status, last transaction status, setup ack and unlock
// Operation
// - set setup overwritten flag (bit 3) when new setup replaces setup data still present (bit 2), unless a stall command for that endpoint comes in the same cycle
// - clear overwritten flag on read, only once setup data write has finished
// - bit 2 reports setup packet present in endpoint buffer
// - bit 1 reports CPU buffer select, 0 primary, 1 secondary
// - setup arrival blocks validate and clear commands for both control endpoints
// - command F4, no data, acknowledges setup and re-enables validate and clear
// - commands A0..AF select error register of ep0 out, ep0 in, ep1..14; one-byte read
// - each new transaction overwrites that endpoint's stored status
// - bit 7 set when new event arrives before previous status read
// - bit 6 holds data PID of last good packet, 0 DATA0, 1 DATA1
// - bits 4..1 hold error code; bit 0 marks successful transfer
// - codes 0 none, 1 PID check, 2 unknown PID, 3 unexpected packet
// - codes 4 token CRC, 5 data CRC, 6 timeout, 7 babble, 8 EOP, 9 NAK
// - codes a stall sent, b overflow, c empty iso packet
// - codes d bit stuffing, e sync, f wrong toggle with data discarded
// - in suspend all registers and buffer memory are write protected
// - after resume register reads are refused until unlock executes
// - unlock command has two write-only data bytes; AA is upper byte
// - commands D0..DF return endpoint status; the read clears the setup overwritten flag
// - lower key byte 37; full key re-enables register and buffer writes
`timescale 1ns/1ps
`include "usbc_cmd_regs.vh"
module usbc_cmd (
   // clock and reset
   input  wire       i_clock,
   input  wire       i_resetn,
   // processor command/data port, from the port logic on this clock
   input  wire       i_cmd_valid,
   input  wire [7:0] i_cmd_code,
   input  wire       i_wr_valid,
   input  wire [7:0] i_wr_data,
   input  wire       i_rd_req,
   // endpoint core events
   input  wire       i_setup_rx,
   input  wire [3:0] i_setup_ep,
   input  wire       i_setup_done,
   input  wire       i_setup_clear,
   input  wire [3:0] i_setup_clear_ep,
   input  wire       i_stall_cmd,
   input  wire [3:0] i_stall_ep,
   input  wire [15:0] i_cpu_buf_sel,
   input  wire       i_xfer_done,
   input  wire [3:0] i_xfer_ep,
   input  wire [3:0] i_xfer_err,
   input  wire       i_xfer_ok,
   input  wire       i_xfer_toggle,
   // power state
   input  wire       i_suspend,
   // read data and permissions
   output reg  [7:0] o_rd_data,
   output reg        o_rd_valid,
   output reg        o_ctrl_buf_cmd_en,
   output reg        o_write_en,
   output reg        o_read_en,
   output reg        o_discard_data
);
   localparam ST_IDLE = 2'b00;
   localparam ST_STAT = 2'b01;
   localparam ST_ERR  = 2'b10;
   localparam ST_KEY  = 2'b11;

   reg [1:0] state_reg;
   reg [3:0] ep_reg;
   reg       key_lo_ok_reg;
   reg       key_byte_reg;
   reg       locked_reg;
   reg       read_locked_reg;
   reg       setup_lock_reg;
   reg [15:0] ovw_reg;
   reg [15:0] setup_reg;
   reg [15:0] writing_reg;
   reg [15:0] missed_reg;
   reg [15:0] status_missed_flag_reg;
   reg [15:0] toggle_reg;
   reg [15:0] ok_reg;
   reg [3:0]  err_mem [0:`USBC_NUM_EP-1];

   function [15:0] ep_hot;
      input [3:0] ep;
      begin
         ep_hot = 16'h0001 << ep;
      end
   endfunction

   wire [15:0] setup_hot = i_setup_rx ? ep_hot(i_setup_ep) : 16'h0000;
   wire [15:0] xfer_hot  = i_xfer_done ? ep_hot(i_xfer_ep) : 16'h0000;
   wire [15:0] sclr_hot  = i_setup_clear ? ep_hot(i_setup_clear_ep) : 16'h0000;
   wire [15:0] stall_hot = i_stall_cmd ? ep_hot(i_stall_ep) : 16'h0000;
   wire [15:0] cmd_hot   = ep_hot(i_cmd_code[3:0]);
   wire        rd_stat   = (state_reg == ST_STAT) && i_rd_req && !read_locked_reg;
   wire        rd_err    = (state_reg == ST_ERR) && i_rd_req && !read_locked_reg;
   wire [15:0] rd_hot    = ep_hot(ep_reg);
   // setup_overwritten_flag clears only once the new setup data has been written
   wire [15:0] ovw_clr   = (rd_stat ? rd_hot : 16'h0000) & ~writing_reg;
   wire [15:0] err_clr   = rd_err ? rd_hot : 16'h0000;
   // enable follows the next lock value so it moves one cycle after its cause
   wire        ctrl_setup = i_setup_rx && (i_setup_ep[3:1] == 3'b000);
   wire        ack_setup  = i_cmd_valid && (i_cmd_code == `USBC_CMD_ACK_SETUP);
   wire        setup_lock_next = ctrl_setup ? 1'b1 : (ack_setup ? 1'b0 : setup_lock_reg);

   wire [7:0] stat_byte = {4'h0, ovw_reg[ep_reg], setup_reg[ep_reg],
                           i_cpu_buf_sel[ep_reg], 1'b0};
   wire [7:0] err_byte  = {status_missed_flag_reg[ep_reg] & missed_reg[ep_reg],
                           toggle_reg[ep_reg], 1'b0, err_mem[ep_reg], ok_reg[ep_reg]};

   integer k;

   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg       <= ST_IDLE;
         ep_reg          <= 4'h0;
         key_lo_ok_reg   <= 1'b0;
         key_byte_reg    <= 1'b0;
         locked_reg      <= 1'b0;
         read_locked_reg <= 1'b0;
         setup_lock_reg  <= 1'b0;
         ovw_reg         <= 16'h0000;
         setup_reg       <= 16'h0000;
         writing_reg     <= 16'h0000;
         missed_reg      <= 16'h0000;
         status_missed_flag_reg      <= 16'h0000;
         toggle_reg      <= 16'h0000;
         ok_reg          <= 16'h0000;
         o_rd_data       <= `USBC_BYTE_ZERO;
         o_rd_valid      <= 1'b0;
         o_ctrl_buf_cmd_en <= 1'b1;
         o_write_en      <= 1'b1;
         o_read_en       <= 1'b1;
         o_discard_data  <= 1'b0;
         for (k = 0; k < `USBC_NUM_EP; k = k + 1)
            err_mem[k] <= `USBC_ERR_NONE;
      end else begin
         o_rd_valid     <= 1'b0;
         o_discard_data <= 1'b0;
         // set wins over clear on every flag below
         ovw_reg     <= (ovw_reg & ~ovw_clr) | (setup_hot & setup_reg & ~stall_hot);
         setup_reg   <= (setup_reg & ~sclr_hot) | setup_hot;
         writing_reg <= (writing_reg & ~(i_setup_done ? ep_hot(i_setup_ep) : 16'h0000))
                        | setup_hot;
         if (i_suspend) begin
            locked_reg      <= 1'b1;
            read_locked_reg <= 1'b1;
         end
         o_write_en <= !(locked_reg || i_suspend);
         o_read_en  <= !(read_locked_reg || i_suspend);
         setup_lock_reg    <= setup_lock_next;
         o_ctrl_buf_cmd_en <= !setup_lock_next;
         // latest transaction replaces stored status
         if (i_xfer_done) begin
            err_mem[i_xfer_ep] <= i_xfer_err;
            ok_reg[i_xfer_ep]  <= i_xfer_ok;
            if (i_xfer_ok)
               toggle_reg[i_xfer_ep] <= i_xfer_toggle;
            o_discard_data <= (i_xfer_err == `USBC_ERR_TOGGLE);
         end
         // missed: second event while previous still status_missed_flag
         missed_reg <= (missed_reg & ~err_clr) | (xfer_hot & status_missed_flag_reg);
         status_missed_flag_reg <= (status_missed_flag_reg & ~err_clr) | xfer_hot;
         case (state_reg)
            ST_IDLE: begin
               if (i_cmd_valid) begin
                  ep_reg <= i_cmd_code[3:0];
                  if (i_cmd_code[7:4] == `USBC_CMD_STAT_BASE)
                     state_reg <= ST_STAT;
                  else if (i_cmd_code[7:4] == `USBC_CMD_ERR_BASE)
                     state_reg <= ST_ERR;
                  else if (i_cmd_code == `USBC_CMD_UNLOCK) begin
                     state_reg    <= ST_KEY;
                     key_byte_reg <= 1'b0;
                  end
               end
            end
            ST_STAT: begin
               if (rd_stat) begin
                  o_rd_data  <= stat_byte;
                  o_rd_valid <= 1'b1;
                  state_reg  <= ST_IDLE;
               end else if (i_cmd_valid || (i_rd_req && read_locked_reg))
                  state_reg <= ST_IDLE;
            end
            ST_ERR: begin
               if (rd_err) begin
                  o_rd_data  <= err_byte;
                  o_rd_valid <= 1'b1;
                  state_reg  <= ST_IDLE;
               end else if (i_cmd_valid || (i_rd_req && read_locked_reg))
                  state_reg <= ST_IDLE;
            end
            ST_KEY: begin
               if (i_cmd_valid)
                  state_reg <= ST_IDLE;
               else if (i_wr_valid) begin
                  if (!key_byte_reg) begin
                     key_lo_ok_reg <= (i_wr_data == `USBC_KEY_LO);
                     key_byte_reg  <= 1'b1;
                  end else begin
                     state_reg <= ST_IDLE;
                     if (key_lo_ok_reg && i_wr_data == `USBC_KEY_HI && !i_suspend) begin
                        locked_reg      <= 1'b0;
                        read_locked_reg <= 1'b0;
                     end // otherwise stays locked
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule

/* File: logic/usbc_cmd_regs.vh */
// command codes, register fields and key values of the setup/error/unlock command block
`ifndef USBC_CMD_REGS_VH
`define USBC_CMD_REGS_VH
`define USBC_CMD_ACK_SETUP   8'hf4
`define USBC_CMD_ERR_BASE    4'ha
`define USBC_CMD_STAT_BASE   4'hd
`define USBC_CMD_UNLOCK      8'hb0
`define USBC_KEY_LO          8'h37
`define USBC_KEY_HI          8'haa
`define USBC_ST_SETUP_OVERWRITTEN_FLAG    3
`define USBC_ST_SETUP        2
`define USBC_ST_CPU_BUFFER_SELECT       1
`define USBC_EC_MISSED       7
`define USBC_EC_TOGGLE       6
`define USBC_EC_ERR_HI       4
`define USBC_EC_ERR_LO       1
`define USBC_EC_OK           0
`define USBC_ERR_NONE        4'h0
`define USBC_ERR_PID_CHK     4'h1
`define USBC_ERR_PID_UNK     4'h2
`define USBC_ERR_UNEXP       4'h3
`define USBC_ERR_TOK_CRC     4'h4
`define USBC_ERR_DAT_CRC     4'h5
`define USBC_ERR_TIMEOUT     4'h6
`define USBC_ERR_BABBLE      4'h7
`define USBC_ERR_EOP         4'h8
`define USBC_ERR_NAK         4'h9
`define USBC_ERR_STALL       4'ha
`define USBC_ERR_OVERFLOW    4'hb
`define USBC_ERR_ISO_EMPTY   4'hc
`define USBC_ERR_STUFF       4'hd
`define USBC_ERR_SYNC        4'he
`define USBC_ERR_TOGGLE      4'hf
`define USBC_NUM_EP          16
`define USBC_BYTE_ZERO       8'h00
`endif

/* File: tb/usbc_cmd_checker.sv */
// port assertions for the command block
`timescale 1ns/1ps
module usbc_cmd_checker (
   input wire       i_clock,
   input wire       i_resetn,
   input wire       i_cmd_valid,
   input wire [7:0] i_cmd_code,
   input wire       i_wr_valid,
   input wire [7:0] i_wr_data,
   input wire       i_rd_req,
   input wire       i_setup_rx,
   input wire [3:0] i_setup_ep,
   input wire       i_xfer_done,
   input wire [3:0] i_xfer_err,
   input wire       i_suspend,
   input wire       o_rd_valid,
   input wire       o_ctrl_buf_cmd_en,
   input wire       o_write_en,
   input wire       o_read_en,
   input wire       o_discard_data
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   a_answer_cause: assert property (o_rd_valid |-> $past(i_rd_req))
      else $error("answer without read request");
   a_answer_pulse: assert property (o_rd_valid && !i_rd_req |=> !o_rd_valid)
      else $error("answer longer than one cycle");
   a_setup_blocks: assert property (i_setup_rx && i_setup_ep < 4'h2 |=> !o_ctrl_buf_cmd_en)
      else $error("control buffer commands not blocked");
   a_ack_enables: assert property (i_cmd_valid && i_cmd_code == 8'hf4 && !i_setup_rx
      && o_write_en |=> o_ctrl_buf_cmd_en)
      else $error("setup ack did not enable");
   a_suspend_locks: assert property (i_suspend |=> !o_write_en && !o_read_en)
      else $error("suspend did not lock");
   a_read_refused: assert property (!o_read_en && i_rd_req ##1 !o_read_en |-> !o_rd_valid)
      else $error("read answered while locked");
   a_toggle_discard: assert property (i_xfer_done && i_xfer_err == 4'hf |-> ##[1:2] o_discard_data)
      else $error("toggle error data kept");
   a_key_unlock: assert property (i_cmd_valid && i_cmd_code == 8'hb0 ##1 i_wr_valid
      && i_wr_data == 8'h37 ##1 i_wr_valid && i_wr_data == 8'haa && !i_suspend ##1 !i_suspend
      |=> o_write_en && o_read_en)
      else $error("key did not unlock");
   a_wrong_key: assert property (!o_write_en && $past(i_wr_valid) && i_wr_valid
      && i_wr_data != 8'haa |-> ##2 !o_write_en)
      else $error("wrong key unlocked");
   c_unlock: cover property (!o_write_en ##1 o_write_en);
   c_refused: cover property (!o_read_en && i_rd_req);
   c_discard: cover property (o_discard_data);
endmodule

/* File: tb/usbc_cmd_tb.sv */
// testbench for the command block
`timescale 1ns/1ps
module usbc_cmd_tb;
   reg         clk = 1'b0, rst_n = 1'b0, s_rx = 1'b0, s_done = 1'b0, x_done = 1'b0;
   reg         x_ok = 1'b0, x_tog = 1'b0, susp = 1'b0, s_clr = 1'b0, stl = 1'b0;
   reg  [3:0]  s_ep = 4'h0, x_ep = 4'h0, x_err = 4'h0, s_clr_ep = 4'h0, stl_ep = 4'h0;
   reg  [15:0] buf_sel = 16'h0000;
   wire        cv, wv, rq, rv, ce, we, re;
   wire [7:0]  cc, wd, rdat;
   integer     failures = 0, total_checks = 0, cycles = 0, i;
   always #4 clk = ~clk;
   usbc_cmd i_usbc_cmd (.i_clock(clk), .i_resetn(rst_n), .i_cmd_valid(cv), .i_cmd_code(cc),
      .i_wr_valid(wv), .i_wr_data(wd), .i_rd_req(rq), .i_setup_rx(s_rx), .i_setup_ep(s_ep),
      .i_setup_done(s_done), .i_setup_clear(s_clr), .i_setup_clear_ep(s_clr_ep),
      .i_stall_cmd(stl), .i_stall_ep(stl_ep), .i_cpu_buf_sel(buf_sel), .i_xfer_done(x_done),
      .i_xfer_ep(x_ep),
      .i_xfer_err(x_err), .i_xfer_ok(x_ok), .i_xfer_toggle(x_tog), .i_suspend(susp),
      .o_rd_data(rdat), .o_rd_valid(rv), .o_ctrl_buf_cmd_en(ce), .o_write_en(we),
      .o_read_en(re), .o_discard_data());
   usbc_cpu_model i_usbc_cpu_model (.i_clock(clk), .i_rd_valid(rv), .i_rd_data(rdat),
      .o_cmd_valid(cv), .o_cmd_code(cc), .o_wr_valid(wv), .o_wr_data(wd), .o_rd_req(rq));
   task conclude;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task rd(input logic [7:0] c, input logic v_exp, input logic [7:0] d_exp);
      logic       v;
      logic [7:0] d;
      i_usbc_cpu_model.cmd(c);
      i_usbc_cpu_model.rd(v, d);
      chk("answer valid", {7'h00, v}, {7'h00, v_exp});
      if (v_exp) begin
         chk("answer byte", d, d_exp);
      end
   endtask
   task xfer(input logic [3:0] ep, input logic [3:0] err, input logic ok);
      {x_done, x_ep, x_err, x_ok, x_tog} = {1'b1, ep, err, ok, ok};
      @(negedge clk);
      x_done = 1'b0;
      @(negedge clk);
   endtask
   task setup(input logic [3:0] ep);
      s_rx = 1'b1;
      s_ep = ep;
      @(negedge clk);
      s_rx = 1'b0;
      s_done = 1'b1;
      @(negedge clk);
      s_done = 1'b0;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         conclude;
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      chk("enables after reset", {5'h00, ce, we, re}, 8'h07);
      for (i = 0; i < 16; i++) begin
         xfer(i[3:0], i[3:0], i == 0);
         rd({4'ha, i[3:0]}, 1'b1, {1'b0, i == 0, 1'b0, i[3:0], i == 0});
      end
      xfer(4'h3, 4'h9, 1'b0);
      xfer(4'h3, 4'h0, 1'b1);
      rd(8'ha3, 1'b1, 8'hc1);
      rd(8'ha3, 1'b1, 8'h41);
      buf_sel = 16'h0020;
      rd(8'hd5, 1'b1, 8'h02);
      setup(4'h0);
      chk("ctrl cmd enable", {7'h00, ce}, 8'h00);
      rd(8'hd0, 1'b1, 8'h04);
      setup(4'h0);
      rd(8'hd0, 1'b1, 8'h0c);
      rd(8'hd0, 1'b1, 8'h04);
      // stall in the same cycle as the new setup: no setup_overwritten_flag
      stl = 1'b1;
      setup(4'h0);
      stl = 1'b0;
      rd(8'hd0, 1'b1, 8'h04);
      s_clr = 1'b1;
      @(negedge clk);
      s_clr = 1'b0;
      rd(8'hd0, 1'b1, 8'h00);
      i_usbc_cpu_model.cmd(8'hf4);
      chk("ctrl cmd enable", {7'h00, ce}, 8'h01);
      susp = 1'b1;
      repeat (2) @(negedge clk);
      chk("suspend lock", {6'h00, we, re}, 8'h00);
      susp = 1'b0;
      rd(8'ha0, 1'b0, 8'h00);
      i_usbc_cpu_model.cmd(8'hb0);
      i_usbc_cpu_model.key(8'h37, 8'h55);
      repeat (2) @(negedge clk);
      chk("wrong key", {6'h00, we, re}, 8'h00);
      i_usbc_cpu_model.cmd(8'hb0);
      i_usbc_cpu_model.key(8'h37, 8'haa);
      repeat (2) @(negedge clk);
      chk("unlocked", {6'h00, we, re}, 8'h03);
      conclude;
   end
endmodule
bind usbc_cmd usbc_cmd_checker i_usbc_cmd_checker (.*);

/* File: tb/usbc_cpu_model.sv */
// processor model driving the command/data port, called at falling edges
`timescale 1ns/1ps
module usbc_cpu_model (
   input  wire       i_clock,
   input  wire       i_rd_valid,
   input  wire [7:0] i_rd_data,
   output reg        o_cmd_valid = 1'b0,
   output reg  [7:0] o_cmd_code = 8'h00,
   output reg        o_wr_valid = 1'b0,
   output reg  [7:0] o_wr_data = 8'h00,
   output reg        o_rd_req = 1'b0
);
   task cmd(input logic [7:0] c);
      o_cmd_valid = 1'b1;
      o_cmd_code = c;
      @(negedge i_clock);
      o_cmd_valid = 1'b0;
      o_cmd_code = ~c;
   endtask
   // low byte first, valid held across both bytes
   task key(input logic [7:0] lo, input logic [7:0] hi);
      o_wr_valid = 1'b1;
      o_wr_data = lo;
      @(negedge i_clock);
      o_wr_data = hi;
      @(negedge i_clock);
      o_wr_valid = 1'b0;
      o_wr_data = ~hi;
   endtask
   task rd(output logic v, output logic [7:0] d);
      o_rd_req = 1'b1;
      @(negedge i_clock);
      v = i_rd_valid;
      d = i_rd_data;
      o_rd_req = 1'b0;
   endtask
endmodule
